// ---- flexible_tdm_input_slot_router.sv ----
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`default_nettype none
module flexible_tdm_input_slot_router
  import tdm_router_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   srst,
  // Avalon-MM register slave
  input  wire logic [7:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic [31:0]                 readdata,
  output logic                        waitrequest,
  // Serial input port zero
  input  wire logic                   port_zero_bit_clock,
  input  wire logic                   port_zero_frame_clock,
  input  wire logic                   serial_input_port_zero_data,
  // Serial input port one
  input  wire logic                   port_one_bit_clock,
  input  wire logic                   port_one_frame_clock,
  input  wire logic                   serial_input_port_one_data,
  // Routed channel samples
  output logic                        chan_valid,
  input  wire logic                   chan_ready,
  output logic [CHAN_W-1:0]           chan_index,
  output logic [23:0]                 chan_data,
  // Routing matrix reservation
  output logic                        standard_inputs_reserved,
  output logic [NUM_CHANNELS-1:0]     chan_standard_path
);
  // ==========================================================
  // Declarations
  logic [ROUTE_W-1:0]      route_q [NUM_CHANNELS];
  logic [1:0]              mode0_q;
  logic [1:0]              mode1_q;
  logic                    ack_q;
  logic [31:0]             rdata_q;
  logic                    overrun_q;
  logic [7:0]              frames_q;

  // Slot store and sequencer state
  logic [7:0]              slot_mem_q [NUM_SLOTS];
  seq_state_t              state_q;
  seq_state_t              state_d;
  logic [CHAN_W-1:0]       chan_q;
  logic [CHAN_W-1:0]       chan_d;

  // Output buffer and capture links
  logic [3:0]              level;
  logic                    fifo_in_ready;
  logic [CHAN_W+23:0]      fifo_out;
  slot_link_if             link0 ();
  slot_link_if             link1 ();

  // ==========================================================
  // Helper functions
  // Byte held in a slot of the combined space, with wrap
  function automatic logic [7:0] slot_byte(input logic [SLOT_W-1:0] idx);
    return slot_mem_q[idx];
  endfunction

  // Sample word, MSB slot on top, zeros below short samples
  function automatic logic [23:0] assemble(input logic [SLOT_W-1:0] start,
                                           input logic [2:0] depth);
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    b0 = slot_byte(start);
    b1 = slot_byte(start + SLOT_W'(1));
    b2 = slot_byte(start + SLOT_W'(2));
    case (depth)
      3'h1:    return {b0, 16'h0000};
      3'h2:    return {b0, b1, 8'h00};
      3'h3:    return {b0, b1, b2};
      default: return 24'h00_0000;
    endcase
  endfunction

  // ==========================================================
  // Port activation and reservation
  wire port0_active  = (mode0_q == WL_SLOT_ROUTING);
  wire port1_active  = (mode1_q == WL_SLOT_ROUTING);
  wire route_active  = port0_active | port1_active;

  // Any routing port claims all channels
  assign standard_inputs_reserved = route_active;

  // Per-channel standard path flags
  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : g_std
      assign chan_standard_path[g] = (route_q[g] == ROUTE_RESET);
    end
  endgenerate

  // ==========================================================
  // Capture front ends: only ports zero and one carry slot routing
  tdm_slot_deserializer u_port0 (
    .clock       (clock),
    .srst        (srst),
    .enable      (port0_active),
    .bit_clock   (port_zero_bit_clock),
    .frame_clock (port_zero_frame_clock),
    .ser_data    (serial_input_port_zero_data),
    .link        (link0.src)
  );

  tdm_slot_deserializer u_port1 (
    .clock       (clock),
    .srst        (srst),
    .enable      (port1_active),
    .bit_clock   (port_one_bit_clock),
    .frame_clock (port_one_frame_clock),
    .ser_data    (serial_input_port_one_data),
    .link        (link1.src)
  );

  // ==========================================================
  // Combined slot space: port zero 0..31, port one 32..63
  always_ff @(posedge clock) begin
    if (link0.byte_valid) begin
      slot_mem_q[{1'b0, link0.slot}] <= link0.data;
    end
    if (link1.byte_valid) begin
      slot_mem_q[{1'b1, link1.slot}] <= link1.data;
    end
  end

  // ==========================================================
  // Channel sequencer
  // Frame marker from port zero when it routes, else port one
  wire frame_tick = port0_active ? link0.frame_start : link1.frame_start;

  // Routing fields of the visited channel
  wire [ROUTE_W-1:0]  cur_cfg   = route_q[chan_q];
  wire [SLOT_W-1:0]   cur_start = cur_cfg[ROUTE_START_LSB +: SLOT_W];
  wire [2:0]          cur_depth = cur_cfg[ROUTE_DEPTH_LSB +: 3];
  wire cur_std      = (cur_cfg == ROUTE_RESET);
  wire cur_routed   = !cur_std && cur_depth >= 3'h1 && cur_depth <= 3'h3;

  // Visit one channel, wait on a full buffer
  wire seq_running  = (state_q == SEQ_RUN);
  wire push         = seq_running & cur_routed;
  wire step         = seq_running & (!cur_routed | fifo_in_ready);
  wire last_chan    = (chan_q == CHAN_W'(NUM_CHANNELS - 1));
  wire [23:0] cur_word = assemble(cur_start, cur_depth);

  // Next state: one channel per cycle, stalled by a full FIFO
  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    case (state_q)
      SEQ_IDLE: begin
        if (frame_tick && route_active) begin
          state_d = SEQ_RUN;
          chan_d  = '0;
        end
      end
      SEQ_RUN: begin
        if (step) begin
          chan_d = chan_q + CHAN_W'(1);
          if (last_chan) begin
            state_d = SEQ_IDLE;
            chan_d  = '0;
          end
        end
      end
      default: begin
        state_d = SEQ_IDLE;
        chan_d  = '0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= SEQ_IDLE;
      chan_q  <= '0;
    end else begin
      state_q <= state_d;
      chan_q  <= chan_d;
    end
  end

  // ==========================================================
  // Output buffer
  sync_fifo #(
    .WIDTH (CHAN_W + 24),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({chan_q, cur_word}),
    .out_valid (chan_valid),
    .out_ready (chan_ready),
    .out_data  (fifo_out),
    .level     (level)
  );

  // Head word split into index and sample
  assign chan_index = fifo_out[CHAN_W+23:24];
  assign chan_data  = fifo_out[23:0];

  // ==========================================================
  // Register bus decode
  wire        req        = read | write;
  wire        first      = req & ~ack_q;
  wire [5:0]  word_idx   = address[7:2];

  // Register hits; route words fill the low offsets
  wire        hit_route  = (word_idx < 6'(NUM_CHANNELS));
  wire        hit_mode0  = (address == PORT0_MODE_OFS);
  wire        hit_mode1  = (address == PORT1_MODE_OFS);
  wire        hit_status = (address == STATUS_OFS);

  // Writes land at the edge that completes the transfer
  wire        wr_take    = write & ack_q;
  wire [CHAN_W-1:0] route_sel = word_idx[CHAN_W-1:0];

  // One wait cycle per request, data from a flop
  assign waitrequest = first;
  assign readdata    = rdata_q;

  // Read mux, zero for unmapped offsets
  wire [31:0] status_word = {12'h000, level, frames_q, 5'h00, seq_running,
                             route_active, overrun_q};
  wire [31:0] rd_mux = hit_route  ? {23'h00_0000, route_q[route_sel]} :
                       hit_mode0  ? {30'h0000_0000, mode0_q} :
                       hit_mode1  ? {30'h0000_0000, mode1_q} :
                       hit_status ? status_word : 32'h0000_0000;

  // Bus handshake and read data
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= first;
      if (read && first) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Routing registers, byte lane writes
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        route_q[i] <= ROUTE_RESET;
      end
    end else if (wr_take && hit_route) begin
      if (byteenable[0]) begin
        route_q[route_sel][7:0] <= writedata[7:0];
      end
      if (byteenable[1]) begin
        route_q[route_sel][8] <= writedata[8];
      end
    end
  end

  // Port mode registers and frame count
  always_ff @(posedge clock) begin
    if (srst) begin
      mode0_q  <= MODE_RESET;
      mode1_q  <= MODE_RESET;
      frames_q <= 8'h00;
    end else begin
      if (wr_take && hit_mode0 && byteenable[0]) begin
        mode0_q <= writedata[1:0];
      end
      if (wr_take && hit_mode1 && byteenable[0]) begin
        mode1_q <= writedata[1:0];
      end
      if (frame_tick && route_active) begin
        frames_q <= frames_q + 8'h01;
      end
    end
  end

  // Overrun clear request, write one to bit zero
  wire ovr_clear = wr_take & hit_status & byteenable[0] & writedata[STAT_OVERRUN];

  // New frame while still draining channels; set beats clear
  always_ff @(posedge clock) begin
    if (srst) begin
      overrun_q <= 1'b0;
    end else if (frame_tick && seq_running) begin
      overrun_q <= 1'b1;
    end else if (ovr_clear) begin
      overrun_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- flexible_tdm_input_slot_router_bench.sv ----
`default_nettype none
module flexible_tdm_input_slot_router_bench
  import tdm_router_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clock, srst, read, write, chan_ready, start, chan_valid;
  logic [7:0]              address;
  logic [31:0]             writedata, readdata;
  logic [3:0]              byteenable;
  logic                    waitrequest, reserved, p0_busy, p1_busy;
  logic                    p0_bclk, p0_fclk, p0_data, p1_bclk, p1_fclk, p1_data;
  logic [CHAN_W-1:0]       chan_index;
  logic [23:0]             chan_data;
  logic [NUM_CHANNELS-1:0] std_path;
  int                      n_mismatch = 0;
  int                      checked = 0;
  // Design and two serial sources
  flexible_tdm_input_slot_router dut (.clock(clock), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .port_zero_bit_clock(p0_bclk),
    .port_zero_frame_clock(p0_fclk), .serial_input_port_zero_data(p0_data),
    .port_one_bit_clock(p1_bclk), .port_one_frame_clock(p1_fclk),
    .serial_input_port_one_data(p1_data), .chan_valid(chan_valid),
    .chan_ready(chan_ready), .chan_index(chan_index), .chan_data(chan_data),
    .standard_inputs_reserved(reserved), .chan_standard_path(std_path));
  tdm_source_model #(.BASE(8'h10)) src0 (.clock(clock), .start(start),
    .bit_clock(p0_bclk), .frame_clock(p0_fclk), .data(p0_data), .busy(p0_busy));
  tdm_source_model #(.BASE(8'h80)) src1 (.clock(clock), .start(start),
    .bit_clock(p1_bclk), .frame_clock(p1_fclk), .data(p1_data), .busy(p1_busy));
  // ==========================================================
  // Helpers
  always #10 clock = ~clock;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n = 0;
    @(posedge clock);
    address <= a;
    writedata <= wd;
    byteenable <= 4'hF;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0);
    rd = readdata;
    check(32'(n), 32'h0000_0002, "bus wait");
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    @(negedge clock);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp, what);
  endtask
  task automatic frame();
    int n = 0;
    @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while (p0_busy !== 1'b0 && n < 3000);
    check(32'(p0_busy), 32'h0, "frame end");
  endtask
  function automatic logic [7:0] slot_byte(input int s);
    return (s < 32) ? 8'(8'h10 + s) : 8'(8'h80 + s - 32);
  endfunction
  function automatic logic [23:0] exp_word(input int s, input int d);
    logic [23:0] w;
    w = {slot_byte(s), slot_byte(s + 1), slot_byte(s + 2)};
    if (d == 1) w[15:0] = 16'h0000;
    if (d == 2) w[7:0] = 8'h00;
    return w;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    close_out();
  end
  // ==========================================================
  // Tests
  initial begin
    logic [31:0] x;
    int          m;
    clock = 1'b0;
    srst = 1'b1;
    {read, write, chan_ready, start, address, writedata, byteenable} = '0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    rdc(8'h00, 32'h0000_01FF, "route 0 reset");
    rdc(8'h5C, 32'h0000_01FF, "route 23 reset");
    rdc(PORT1_MODE_OFS, 32'h0000_0000, "mode reset");
    rdc(8'h80, 32'h0000_0000, "unmapped");
    check(32'(std_path), 32'h00FF_FFFF, "std path reset");
    // Routed channel while no port is in slot mode
    wr(8'h00, 32'h0000_00C4);
    frame();
    check(32'(chan_valid), 32'h0, "mode off");
    wr(8'h00, 32'h0000_01FF);
    wr(PORT0_MODE_OFS, 32'h0000_0003);
    check(32'(reserved), 32'h1, "reserved");
    wr(PORT1_MODE_OFS, 32'h0000_0003);
    frame();
    // Ten channels, ascending slots, depths 1 to 3, one across the ports
    for (int n = 0; n < 10; n++) wr(8'(4 * n), 32'((n % 3 + 1) * 64 + 6 * n));
    rdc(8'h14, 32'h0000_00DE, "route 5");
    check(32'(std_path), 32'h00FF_FC00, "std path");
    frame();
    bus(1'b0, STATUS_OFS, 32'h0, x);
    check(x & 32'h000F_0006, 32'h0008_0006, "fifo full");
    chan_ready <= 1'b1;
    for (int n = 0; n < 10; n++) begin
      m = 0;
      do begin
        @(negedge clock);
        m++;
      end while (chan_valid !== 1'b1 && m < 100);
      check(32'(chan_valid), 32'h1, "valid");
      check(32'(chan_index), 32'(n), "index");
      check(32'(chan_data), 32'(exp_word(6 * n, n % 3 + 1)), "sample");
      @(posedge clock);
    end
    chan_ready <= 1'b0;
    @(negedge clock);
    check(32'(chan_valid), 32'h0, "drained");
    wr(PORT0_MODE_OFS, 32'h0000_0002);
    check(32'(reserved), 32'h1, "one port left");
    wr(PORT1_MODE_OFS, 32'h0000_0000);
    check(32'(reserved), 32'h0, "released");
    close_out();
  end
endmodule
`default_nettype wire

// ---- flexible_tdm_input_slot_router_properties.sv ----
`default_nettype none
module router_checker
  import tdm_router_pkg::*;
(
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    srst,
  // Register bus
  input wire logic [7:0]              address,
  input wire logic                    read,
  input wire logic                    write,
  input wire logic [31:0]             writedata,
  input wire logic [3:0]              byteenable,
  input wire logic [31:0]             readdata,
  input wire logic                    waitrequest,
  // Channel stream and reservation
  input wire logic                    chan_valid,
  input wire logic                    chan_ready,
  input wire logic [CHAN_W-1:0]       chan_index,
  input wire logic [23:0]             chan_data,
  input wire logic                    standard_inputs_reserved,
  input wire logic [NUM_CHANNELS-1:0] chan_standard_path
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Register mirror
  logic [8:0]              route_q [NUM_CHANNELS];
  logic [1:0]              mode0_q;
  logic [1:0]              mode1_q;
  logic [CHAN_W-1:0]       last_q;
  logic                    have_q;
  logic [NUM_CHANNELS-1:0] std_exp;
  wire                     wr_done = write && !waitrequest;
  wire                     to_route = wr_done && (address < PORT0_MODE_OFS);
  wire                     xfer = chan_valid && chan_ready;
  wire [8:0]               head = route_q[chan_index];
  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_std
    assign std_exp[g] = (route_q[g] == ROUTE_RESET);
  end
  // Mirror updates and last transferred index
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int n = 0; n < NUM_CHANNELS; n++) route_q[n] <= ROUTE_RESET;
      mode0_q <= MODE_RESET;
      mode1_q <= MODE_RESET;
      have_q  <= 1'b0;
    end else begin
      if (to_route && byteenable[0]) route_q[address[6:2]][7:0] <= writedata[7:0];
      if (to_route && byteenable[1]) route_q[address[6:2]][8] <= writedata[8];
      if (wr_done && address == PORT0_MODE_OFS && byteenable[0]) mode0_q <= writedata[1:0];
      if (wr_done && address == PORT1_MODE_OFS && byteenable[0]) mode1_q <= writedata[1:0];
      if (xfer) last_q <= chan_index;
      have_q <= xfer || (have_q && chan_valid);
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_req_wait;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    (read || write) && !waitrequest;
  endsequence
  AST_ONE_WAIT: assert property (s_req_wait |=> s_answer)
    else $error("bus wait not one cycle");
  AST_IDLE_NO_WAIT: assert property (!(read || write) |-> !waitrequest)
    else $error("wait without request");
  AST_UNMAPPED_ZERO: assert property (s_answer ##0 (read && address > 8'h6B) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_ROUTE_READBACK: assert property (
    s_answer ##0 (read && address < PORT0_MODE_OFS) |-> readdata[8:0] == route_q[address[6:2]])
    else $error("route readback wrong");
  AST_STD_PATH: assert property (chan_standard_path == std_exp)
    else $error("standard path flags wrong");
  AST_RESERVED: assert property (
    standard_inputs_reserved == (mode0_q == WL_SLOT_ROUTING || mode1_q == WL_SLOT_ROUTING))
    else $error("reservation wrong");
  AST_NEEDS_MODE: assert property ($rose(chan_valid) |-> standard_inputs_reserved)
    else $error("output without slot mode");
  AST_ASCENDING: assert property (xfer && have_q |-> chan_index > last_q)
    else $error("channel order wrong");
  AST_ROUTED_ONLY: assert property (
    chan_valid |-> head != ROUTE_RESET && head[8:6] inside {3'h1, 3'h2, 3'h3})
    else $error("unrouted channel sent");
  AST_LOW_ZERO: assert property (
    chan_valid && head[8:6] != 3'h3 |-> chan_data[7:0] == 8'h00
      && (head[8:6] != 3'h1 || chan_data[15:8] == 8'h00))
    else $error("low bits not zero");
  AST_HEAD_HOLDS: assert property (
    chan_valid && !chan_ready |=> chan_valid && $stable(chan_index) && $stable(chan_data))
    else $error("head changed while stalled");
endmodule
bind flexible_tdm_input_slot_router router_checker u_checker (
  .clock(clock), .srst(srst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .chan_valid(chan_valid), .chan_ready(chan_ready),
  .chan_index(chan_index), .chan_data(chan_data),
  .standard_inputs_reserved(standard_inputs_reserved),
  .chan_standard_path(chan_standard_path));
`default_nettype wire

// ---- slot_link_if.sv ----
`default_nettype none
// ==========================================================
// Byte slots from one serial port
interface slot_link_if;
  logic       byte_valid;
  logic [4:0] slot;
  logic [7:0] data;
  logic       frame_start;
  modport src (output byte_valid, slot, data, frame_start);
  modport snk (input byte_valid, slot, data, frame_start);
endinterface
`default_nettype wire

// ---- sync_fifo.sv ----
`default_nettype none
module sync_fifo #(
  parameter int unsigned WIDTH = 29,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     srst,
  // Fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]    level
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  wire  [AW:0]      used = wr_q - rd_q;

  // Full and empty from pointer distance
  assign in_ready  = (used != (AW+1)'(DEPTH));
  assign out_valid = (used != '0);
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign level     = ($clog2(DEPTH+1))'(used);

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- tdm_router_pkg.sv ----
`default_nettype none
package tdm_router_pkg;
  // ==========================================================
  // Stream geometry
  localparam int unsigned SLOTS_PER_PORT = 32;
  localparam int unsigned NUM_PORTS      = 2;
  localparam int unsigned NUM_SLOTS      = SLOTS_PER_PORT * NUM_PORTS;
  localparam int unsigned NUM_CHANNELS   = 24;
  localparam int unsigned BITS_PER_SLOT  = 8;
  localparam int unsigned FIFO_DEPTH     = 8;
  localparam int unsigned SLOT_W         = 6;
  localparam int unsigned CHAN_W         = 5;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ROUTE_BASE_OFS = 8'h00;
  localparam logic [7:0] PORT0_MODE_OFS = 8'h60;
  localparam logic [7:0] PORT1_MODE_OFS = 8'h64;
  localparam logic [7:0] STATUS_OFS     = 8'h68;

  // ==========================================================
  // Field layouts and reset values
  localparam int unsigned ROUTE_START_LSB = 0;
  localparam int unsigned ROUTE_DEPTH_LSB = 6;
  localparam int unsigned ROUTE_W         = 9;
  localparam logic [8:0]  ROUTE_RESET     = 9'h1FF;
  localparam logic [1:0]  WL_SLOT_ROUTING = 2'h3;
  localparam logic [1:0]  MODE_RESET      = 2'h0;
  localparam int unsigned STAT_OVERRUN    = 0;
  localparam int unsigned STAT_ACTIVE     = 1;
  localparam int unsigned STAT_BUSY       = 2;
  localparam int unsigned STAT_FRAMES_LSB = 8;
  localparam int unsigned STAT_LEVEL_LSB  = 16;

  // Sequencer states
  typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage
`default_nettype wire

// ---- tdm_slot_deserializer.sv ----
`default_nettype none
module tdm_slot_deserializer
  import tdm_router_pkg::*;
(
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  srst,
  // Control
  input  wire logic  enable,
  // Serial pins
  input  wire logic  bit_clock,
  input  wire logic  frame_clock,
  input  wire logic  ser_data,
  // Byte slots out
  slot_link_if.src   link
);
  logic       bclk_q;
  logic       frame_q;
  logic       armed_q;
  logic [2:0] bit_q;
  logic [4:0] slot_q;
  logic [7:0] shift_q;

  // Edge detection on the sampled clocks
  wire bclk_rise   = bit_clock & ~bclk_q;
  wire frame_rise  = bclk_rise & frame_clock & ~frame_q;
  wire take_bit    = bclk_rise & (armed_q | frame_rise);
  wire byte_done   = take_bit & (frame_rise ? 1'b0 : (bit_q == 3'h7));
  wire [7:0] shift_d = {shift_q[6:0], ser_data};

  // Bit and slot counting, MSB first, 32 slots per frame
  always_ff @(posedge clock) begin
    if (srst) begin
      bclk_q  <= 1'b0;
      frame_q <= 1'b0;
      armed_q <= 1'b0;
      bit_q   <= 3'h0;
      slot_q  <= 5'h00;
      shift_q <= 8'h00;
    end else begin
      bclk_q <= bit_clock;
      if (bclk_rise) frame_q <= frame_clock;
      if (!enable) begin
        armed_q <= 1'b0;
      end else if (frame_rise) begin
        armed_q <= 1'b1;
        bit_q   <= 3'h1;
        slot_q  <= 5'h00;
        shift_q <= {7'h00, ser_data};
      end else if (take_bit) begin
        shift_q <= shift_d;
        bit_q   <= bit_q + 3'h1;
        if (byte_done) begin
          slot_q <= slot_q + 5'h01;
          if (slot_q == 5'(SLOTS_PER_PORT - 1)) armed_q <= 1'b0;
        end
      end
    end
  end

  // Registered byte output
  always_ff @(posedge clock) begin
    if (srst) begin
      link.byte_valid  <= 1'b0;
      link.frame_start <= 1'b0;
      link.slot        <= 5'h00;
      link.data        <= 8'h00;
    end else begin
      link.byte_valid  <= enable & byte_done;
      link.frame_start <= enable & frame_rise;
      if (byte_done) begin
        link.slot <= slot_q;
        link.data <= shift_d;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tdm_source_model.sv ----
`default_nettype none
module tdm_source_model #(
  parameter logic [7:0] BASE = 8'h00
) (
  // Clock and request
  input  wire logic clock,
  input  wire logic start,
  // Serial pins and status
  output var logic  bit_clock,
  output var logic  frame_clock,
  output var logic  data,
  output var logic  busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] v;
  // One frame of 32 slots, MSB first; bit clock still between frames
  initial begin
    bit_clock = 1'b0;
    frame_clock = 1'b0;
    data = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (start === 1'b1) begin
        busy <= 1'b1;
        for (int b = 0; b < 256; b++) begin
          v = BASE + 8'(b / 8);
          data <= v[7 - (b % 8)];
          frame_clock <= (b < 128);
          repeat (2) @(posedge clock);
          bit_clock <= 1'b1;
          repeat (2) @(posedge clock);
          bit_clock <= 1'b0;
        end
        data <= ~data;
        frame_clock <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
